// File: rmc_mode_ctrl.sv
// Purpose: Sleep / pulse-width / keep-alive mode and switching rate control
// Assumes: Inputs synchronous to nothing; analog flags come from comparators
// Notes: Sleep state doubles as the logic reset of all counters
`timescale 1ns/1ps
module rmc_mode_ctrl import rmc_pkg::*; #(
    parameter int unsigned BASE_DIV = BASE_DIV_DFLT,
    parameter int unsigned SLEEP_DLY = SLEEP_DLY_CYC,
    parameter int unsigned PFM_DLY = PFM_DLY_TICKS
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Host pins
    input wire logic shutdown_request_n,
    input wire logic mode_select_sync_in,
    // Comparator flags
    input wire rmc_flags_t flags_in,
    // Switching control and status
    output logic switch_pulse,
    output logic switching_en,
    output rmc_status_t status
);

    localparam int unsigned OSC_W = $clog2(BASE_DIV);
    localparam int unsigned LOST_CYC = 2 * BASE_DIV;
    localparam int unsigned PER_W = $clog2(LOST_CYC + 1);
    localparam int unsigned SLP_W = $clog2(SLEEP_DLY);
    localparam int unsigned PFM_W = $clog2(PFM_DLY);
    localparam int unsigned SYNC_MIN = (BASE_DIV * 10 + SYNC_MAX_X10 - 1) / SYNC_MAX_X10;
    localparam int unsigned SYNC_MAX = (BASE_DIV * 10) / SYNC_MIN_X10;
    localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(BASE_DIV - 1);
    localparam logic [PER_W-1:0] PER_LOST = PER_W'(LOST_CYC);
    localparam logic [PER_W-1:0] PER_MIN = PER_W'(SYNC_MIN);
    localparam logic [PER_W-1:0] PER_MAX = PER_W'(SYNC_MAX);
    localparam logic [PER_W-1:0] PER_ONE = PER_W'(1);
    localparam logic [SLP_W-1:0] SLP_LAST = SLP_W'(SLEEP_DLY - 1);
    localparam logic [PFM_W-1:0] PFM_LAST = PFM_W'(PFM_DLY - 1);

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [FLAG_W+1:0] raw_in;
    logic [FLAG_W+1:0] syn_out;
    logic sleep_n_s;
    logic mode_s;
    rmc_flags_t flg_s;

    assign raw_in = {shutdown_request_n, mode_select_sync_in, flags_in};

    rmc_sync #(
        .W(FLAG_W + 2)
    ) u_in_sync (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .d(raw_in),
        .q(syn_out)
    );

    assign sleep_n_s = syn_out[FLAG_W+1];
    assign mode_s = syn_out[FLAG_W];
    assign flg_s = rmc_flags_t'(syn_out[FLAG_W-1:0]);

    ////////////////////////////////////////////////////////////////////////////////
    // State declarations

    rmc_state_t state_q;
    rmc_state_t state_d;
    logic [SLP_W-1:0] slp_cnt_q;
    logic [SLP_W-1:0] slp_cnt_d;
    logic [PFM_W-1:0] pfm_cnt_q;
    logic [PFM_W-1:0] pfm_cnt_d;
    logic [OSC_W-1:0] osc_cnt_q;
    logic [OSC_W-1:0] osc_cnt_d;
    logic [1:0] fold_q;
    logic [1:0] fold_d;
    rmc_freq_t freq_q;
    rmc_freq_t freq_d;
    logic pulse_q;
    logic pulse_d;
    logic mode_prev_q;
    logic mode_prev_d;
    logic [PER_W-1:0] per_q;
    logic [PER_W-1:0] per_d;
    logic lock_q;
    logic lock_d;

    logic awake;
    logic slp_done;
    logic pfm_arm;
    logic osc_tick;
    logic mode_rise;

    assign awake = (state_q != ST_SLEEP);
    assign osc_tick = awake && (osc_cnt_q == OSC_LAST);
    assign mode_rise = mode_s && !mode_prev_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Mode state machine

    always_comb begin
        state_d = state_q;
        pfm_cnt_d = pfm_cnt_q;
        slp_done = awake && !sleep_n_s && (slp_cnt_q == SLP_LAST);
        if (awake && !sleep_n_s && !slp_done) begin
            slp_cnt_d = slp_cnt_q + SLP_W'(1);
        end else begin
            slp_cnt_d = '0;
        end
        pfm_arm = !mode_s && flg_s.ss_above_2v3 && flg_s.output_valid_flag;
        case (state_q)
            ST_SLEEP: begin
                pfm_cnt_d = '0;
                if (sleep_n_s) begin
                    state_d = ST_PWM;
                end
            end
            ST_PWM: begin
                if (slp_done) begin
                    state_d = ST_SLEEP;
                    pfm_cnt_d = '0;
                end else if (!pfm_arm) begin
                    pfm_cnt_d = '0;
                end else if (osc_tick) begin
                    if (pfm_cnt_q == PFM_LAST) begin
                        state_d = ST_PFM;
                        pfm_cnt_d = '0;
                    end else begin
                        pfm_cnt_d = pfm_cnt_q + PFM_W'(1);
                    end
                end
            end
            ST_PFM: begin
                pfm_cnt_d = '0;
                if (slp_done) begin
                    state_d = ST_SLEEP;
                end else if (mode_s) begin
                    state_d = ST_PWM;
                end
            end
            default: begin
                state_d = ST_SLEEP;
                pfm_cnt_d = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= RST_STATE;
            slp_cnt_q <= '0;
            pfm_cnt_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            slp_cnt_q <= slp_cnt_d;
            pfm_cnt_q <= pfm_cnt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // External clock measurement

    always_comb begin
        mode_prev_d = mode_s;
        per_d = per_q;
        lock_d = lock_q;
        if (!awake) begin
            per_d = PER_LOST;
            lock_d = 1'b0;
        end else if (mode_rise) begin
            per_d = PER_ONE;
            lock_d = (per_q >= PER_MIN) && (per_q <= PER_MAX);
        end else if (per_q != PER_LOST) begin
            per_d = per_q + PER_ONE;
        end else begin
            lock_d = 1'b0; // Clock stopped
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_prev_q <= 1'b0;
            per_q <= PER_LOST;
            lock_q <= 1'b0;
        end else if (clk_en) begin
            mode_prev_q <= mode_prev_d;
            per_q <= per_d;
            lock_q <= lock_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator, fold-back and switching pulses

    always_comb begin
        osc_cnt_d = (!awake || osc_tick) ? '0 : osc_cnt_q + OSC_W'(1);
        if (!awake) begin
            fold_d = 2'h0;
        end else if (osc_tick) begin
            fold_d = fold_q + 2'h1;
        end else begin
            fold_d = fold_q;
        end
        if (flg_s.fb_short || !flg_s.fb_above_200) begin
            freq_d = FREQ_QUARTER;
        end else if (!flg_s.fb_above_400) begin
            freq_d = FREQ_HALF;
        end else if (lock_q) begin
            freq_d = FREQ_SYNC;
        end else begin
            freq_d = FREQ_FULL;
        end
        case (state_q)
            ST_PWM: begin
                case (freq_q)
                    FREQ_QUARTER: pulse_d = osc_tick && (fold_q == 2'h0);
                    FREQ_HALF: pulse_d = osc_tick && !fold_q[0];
                    FREQ_SYNC: pulse_d = mode_rise;
                    default: pulse_d = osc_tick;
                endcase
            end
            ST_PFM: pulse_d = osc_tick && flg_s.pfm_demand;
            default: pulse_d = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            osc_cnt_q <= '0;
            fold_q <= 2'h0;
            freq_q <= RST_FREQ;
            pulse_q <= 1'b0;
        end else if (clk_en) begin
            osc_cnt_q <= osc_cnt_d;
            fold_q <= fold_d;
            freq_q <= freq_d;
            pulse_q <= pulse_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign switch_pulse = pulse_q;
    assign switching_en = awake;
    assign status.mode = state_q;
    assign status.freq = freq_q;
    assign status.sync_locked = lock_q;
    assign status.pfm_pending = (pfm_cnt_q != '0);
    assign status.sleep_pending = (slp_cnt_q != '0);

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (!arst_n);

    sequence s_awake_to_sleep;
        (state_q != ST_SLEEP) ##1 (state_q == ST_SLEEP);
    endsequence

    sequence s_pwm_to_pfm;
        (state_q == ST_PWM) ##1 (state_q == ST_PFM);
    endsequence

    a_sleep_quiet: assert property (
        (state_q == ST_SLEEP) && $past(state_q) == ST_SLEEP && $past(clk_en)
        |-> !switch_pulse && !switching_en)
        else $error("Switching while asleep");

    a_sleep_delay: assert property (
        s_awake_to_sleep |-> $past(slp_cnt_q) == SLP_LAST && !$past(sleep_n_s))
        else $error("Sleep entered before the filter delay");

    a_glitch_reject: assert property (
        awake && sleep_n_s && clk_en |=> slp_cnt_q == '0)
        else $error("Sleep filter not cleared by a high input");

    a_mode_ignored: assert property (
        (state_q == ST_SLEEP) && !sleep_n_s |=> state_q == ST_SLEEP)
        else $error("Woke while shutdown request low");

    a_pwm_base: assert property (
        (state_q == ST_PWM) && (freq_q == FREQ_FULL) && osc_tick && clk_en |=> switch_pulse)
        else $error("Missing base rate pulse");

    a_pfm_rate: assert property (
        (state_q == ST_PFM) && clk_en |=> switch_pulse == $past(osc_tick && flg_s.pfm_demand))
        else $error("Keep-alive pulse not tied to demand");

    a_pfm_gate: assert property (
        (state_q == ST_PWM) && !(flg_s.ss_above_2v3 && flg_s.output_valid_flag) && clk_en
        |=> pfm_cnt_q == '0 && state_q != ST_PFM)
        else $error("Keep-alive count ran without its conditions");

    a_pfm_count: assert property (
        s_pwm_to_pfm |-> $past(pfm_cnt_q) == PFM_LAST && $past(osc_tick))
        else $error("Keep-alive entered before the full count");

    a_sync_follow: assert property (
        (state_q == ST_PWM) && (freq_q == FREQ_SYNC) && mode_rise && clk_en |=> switch_pulse)
        else $error("Locked pulse missing on clock edge");

    a_fold_half: assert property (
        flg_s.fb_above_200 && !flg_s.fb_above_400 && !flg_s.fb_short && clk_en
        |=> freq_q == FREQ_HALF)
        else $error("Half rate not selected");

    a_short_fold: assert property (
        flg_s.fb_short && clk_en |=> freq_q == FREQ_QUARTER)
        else $error("Short did not force quarter rate");

    a_fold_full: assert property (
        flg_s.fb_above_200 && flg_s.fb_above_400 && !flg_s.fb_short && !lock_q && clk_en
        |=> freq_q == FREQ_FULL)
        else $error("Full rate not selected");

    a_input_sync: assert property (
        $past(clk_en) && $past(clk_en, 2) |-> sleep_n_s == $past(shutdown_request_n, 2))
        else $error("Shutdown input not two-flop synchronised");

endmodule

// File: rmc_pkg.sv
// Purpose: Shared constants and types for the regulator mode controller
// Assumes: 40 MHz system clock standing in for the internal oscillator
// Notes: Sleep cycle count derives from a nanosecond time; reset values live here too
package rmc_pkg;

    // Timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned SLEEP_DLY_NS = 103000;
    localparam int unsigned SLEEP_DLY_CYC = (SLEEP_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PFM_DLY_TICKS = 2048;
    localparam int unsigned BASE_DIV_DFLT = 40;

    // Sync window, ratio to base frequency times ten
    localparam int unsigned SYNC_MIN_X10 = 12;
    localparam int unsigned SYNC_MAX_X10 = 15;

    // Operating modes
    typedef enum logic [2:0] {
        ST_SLEEP = 3'h1,
        ST_PWM = 3'h2,
        ST_PFM = 3'h4
    } rmc_state_t;

    // Switching rate selection
    typedef enum logic [1:0] {
        FREQ_QUARTER = 2'h0,
        FREQ_HALF = 2'h1,
        FREQ_FULL = 2'h2,
        FREQ_SYNC = 2'h3
    } rmc_freq_t;

    // Comparator-derived flags
    typedef struct packed {
        logic fb_short;
        logic fb_above_400;
        logic fb_above_200;
        logic ss_above_2v3;
        logic output_valid_flag;
        logic pfm_demand;
    } rmc_flags_t;

    localparam int unsigned FLAG_W = $bits(rmc_flags_t);

    // Status seen by the rest of the chip
    typedef struct packed {
        rmc_state_t mode;
        rmc_freq_t freq;
        logic sync_locked;
        logic pfm_pending;
        logic sleep_pending;
    } rmc_status_t;

    // Values after reset
    localparam rmc_state_t RST_STATE = ST_SLEEP;
    localparam rmc_freq_t RST_FREQ = FREQ_QUARTER;

endpackage

// File: rmc_sync.sv
// Purpose: Two-flop synchroniser for a group of inputs
// Assumes: Inputs may change at any time relative to clk_sys
// Notes: Stage one feeds stage two only; clear value is zero
`timescale 1ns/1ps
module rmc_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = d;
        sync_d = meta_q;
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else if (clk_en) begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign q = sync_q;

endmodule

// File: rmc_host_model.sv
// Purpose: Host model driving the shutdown and mode pins
// Assumes: Bench gives levels; pins change just after a clock edge
// Notes: Sync clock toggles every HALF cycles while enabled
`timescale 1ns/1ps
module rmc_host_model #(
    parameter int unsigned HALF = 3
) (
    // Clock
    input wire logic clk_sys,
    // Bench commands
    input wire logic wake,
    input wire logic mode_hi,
    input wire logic sync_on,
    // Pins
    output logic shutdown_request_n,
    output logic mode_select_sync_in
);
    int unsigned cnt = 0;
    logic clk_q = 1'b0;
    // Pins start low: device asleep, keep-alive requested
    logic sd_q = 1'b0;
    logic ms_q = 1'b0;

    assign shutdown_request_n = sd_q;
    assign mode_select_sync_in = ms_q;

    always @(posedge clk_sys) begin
        cnt <= (cnt + 1 >= HALF) ? 0 : cnt + 1;
        if (cnt + 1 >= HALF) begin
            clk_q <= ~clk_q;
        end
        sd_q <= wake;
        // Host raises mode select to ask for full current
        ms_q <= sync_on ? clk_q : mode_hi;
    end
endmodule

// File: test_rmc_mode_ctrl.sv
// Purpose: Self-checking bench for the regulator mode controller
// Assumes: Short counts: base divider 8, sleep delay 20, keep-alive delay 8
// Notes: Sync clock period 6 cycles sits inside the lock window
`timescale 1ns/1ps
module test_rmc_mode_ctrl;
    import rmc_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic clk_en = 1'b1;
    logic wake = 1'b0;
    logic mode_hi = 1'b0;
    logic sync_on = 1'b0;
    logic shutdown_request_n;
    logic mode_select_sync_in;
    rmc_flags_t flags = 6'h1e;
    logic switch_pulse;
    logic switching_en;
    rmc_status_t status;
    int miscompares = 0;
    int num_checks = 0;
    int c;
    int t;

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    rmc_host_model host (.clk_sys(clk_sys), .wake(wake), .mode_hi(mode_hi), .sync_on(sync_on),
        .shutdown_request_n(shutdown_request_n), .mode_select_sync_in(mode_select_sync_in));

    rmc_mode_ctrl #(.BASE_DIV(8), .SLEEP_DLY(20), .PFM_DLY(8)) dut (.clk_sys(clk_sys),
        .arst_n(arst_n), .clk_en(clk_en), .shutdown_request_n(shutdown_request_n),
        .mode_select_sync_in(mode_select_sync_in), .flags_in(flags),
        .switch_pulse(switch_pulse), .switching_en(switching_en), .status(status));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic set(input logic w, input logic m, input logic s, input logic [5:0] f);
        @(posedge clk_sys);
        wake <= w;
        mode_hi <= m;
        sync_on <= s;
        flags <= f;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic pulses(input int n, output int k);
        k = 0;
        repeat (n) begin
            cyc(1);
            if (switch_pulse === 1'b1) k++;
        end
    endtask

    task automatic wait_mode(input rmc_state_t m, input int lim, output int k);
        k = 0;
        while (status.mode !== m && k < lim) begin
            cyc(1);
            k++;
        end
    endtask

    task automatic print_verdict;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_asleep;
        set(0, 1, 0, 6'h1e);
        cyc(10);
        check("mode asleep", status.mode, ST_SLEEP);
        check("enable asleep", switching_en, 1'b0);
        pulses(20, c);
        check("pulses asleep", c, 0);
    endtask

    task automatic t_wake;
        set(1, 1, 0, 6'h1e);
        cyc(1);
        check("mode before sync", status.mode, ST_SLEEP);
        wait_mode(ST_PWM, 10, t);
        check("mode awake", status.mode, ST_PWM);
        check("enable awake", switching_en, 1'b1);
    endtask

    task automatic t_fold;
        logic [5:0] fl[4] = '{6'h1e, 6'h0e, 6'h06, 6'h3e};
        rmc_freq_t fq[4] = '{FREQ_FULL, FREQ_HALF, FREQ_QUARTER, FREQ_QUARTER};
        int np[4] = '{16, 8, 4, 4};
        for (int i = 0; i < 4; i++) begin
            set(1, 1, 0, fl[i]);
            cyc(40);
            check("rate", status.freq, fq[i]);
            pulses(128, c);
            check("pulse count", c, np[i]);
        end
    endtask

    task automatic t_keep_alive;
        set(1, 0, 0, 6'h1c);
        cyc(120);
        check("mode no valid", status.mode, ST_PWM);
        set(1, 0, 0, 6'h1e);
        cyc(20);
        check("keep-alive pending", status.pfm_pending, 1'b1);
        check("mode counting", status.mode, ST_PWM);
        wait_mode(ST_PFM, 200, t);
        check("mode keep-alive", status.mode, ST_PFM);
        check("count long enough", t >= 36, 1'b1);
        pulses(64, c);
        check("pulses no demand", c, 0);
        set(1, 0, 0, 6'h1f);
        cyc(4);
        pulses(64, c);
        check("pulses demand", c, 8);
        set(1, 1, 0, 6'h1e);
        wait_mode(ST_PWM, 10, t);
        check("back to pulse-width", status.mode, ST_PWM);
    endtask

    task automatic t_sync;
        set(1, 1, 1, 6'h1e);
        cyc(60);
        check("locked", status.sync_locked, 1'b1);
        check("rate sync", status.freq, FREQ_SYNC);
        check("mode sync", status.mode, ST_PWM);
        pulses(60, c);
        check("sync pulses", c, 10);
        set(1, 1, 0, 6'h1e);
        cyc(30);
        check("unlocked", status.sync_locked, 1'b0);
    endtask

    task automatic t_sleep;
        set(0, 1, 0, 6'h1e);
        cyc(10);
        set(1, 1, 0, 6'h1e);
        cyc(40);
        check("glitch ignored", status.mode, ST_PWM);
        set(0, 1, 0, 6'h1e);
        cyc(12);
        check("sleep pending", status.sleep_pending, 1'b1);
        check("mode delaying", status.mode, ST_PWM);
        wait_mode(ST_SLEEP, 40, t);
        check("mode slept", status.mode, ST_SLEEP);
        check("enable slept", switching_en, 1'b0);
        check("delay long enough", t >= 8, 1'b1);
    endtask

    task automatic t_freeze;
        @(posedge clk_sys);
        clk_en <= 1'b0;
        set(1, 1, 0, 6'h1e);
        cyc(20);
        check("mode frozen", status.mode, ST_SLEEP);
        check("enable frozen", switching_en, 1'b0);
        pulses(8, c);
        check("pulses frozen", c, 0);
        @(posedge clk_sys);
        clk_en <= 1'b1;
        wait_mode(ST_PWM, 10, t);
        check("mode after freeze", status.mode, ST_PWM);
        check("wake latency", t >= 3, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_asleep();
        t_wake();
        t_fold();
        t_keep_alive();
        t_sync();
        t_sleep();
        t_freeze();
        print_verdict();
    end

    initial begin
        #200000;
        miscompares++;
        print_verdict();
    end
endmodule
